// ==== core/ptrng_core.v ====
`timescale 1ns/1ns
`include "ptrng_defines.vh"
module ptrng_core #(
  parameter ENHANCED    = 1,
  parameter WORD_BITS   = `PTRNG_WORD_BITS,
  parameter FIFO_DEPTH  = `PTRNG_FIFO_DEPTH,
  parameter RUN_LIMIT   = `PTRNG_RUN_LIMIT,
  parameter WIN_BITS    = `PTRNG_WIN_BITS,
  parameter ONES_LO     = `PTRNG_ONES_LO,
  parameter ONES_HI     = `PTRNG_ONES_HI,
  parameter STARTUP_WIN = `PTRNG_STARTUP_WINS
) (
  input  wire                 clock,
  input  wire                 resetn,
  input  wire                 start,
  input  wire                 sw_shutdown,
  input  wire                 raw_bit,
  input  wire                 attack_alarm,
  output reg  [WORD_BITS-1:0] rnd_data,
  output reg                  rnd_valid,
  input  wire                 rnd_ready,
  output reg                  running,
  output reg                  fail_sticky,
  output reg                  startup_done
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_TEST = 4'b0010;
  localparam ST_RUN  = 4'b0100;
  localparam ST_FAIL = 4'b1000;

  // ========================================================
  // raw bit and alarm synchronisers (three stages)
  // a level must stand two cycles to count; one-cycle glitches are lost
  reg [2:0] raw_sync;
  reg [2:0] alm_sync;
  reg       raw_q;
  reg       alm_q;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      raw_sync <= 3'h0;
      alm_sync <= 3'h0;
      raw_q    <= 1'b0;
      alm_q    <= 1'b0;
    end else begin
      raw_sync <= {raw_sync[1:0], raw_bit};
      alm_sync <= {alm_sync[1:0], attack_alarm};
      if (raw_sync[1] == raw_sync[2]) begin
        raw_q <= raw_sync[2];
      end
      if (alm_sync[1] == alm_sync[2]) begin
        alm_q <= alm_sync[2];
      end
    end
  end

  // ========================================================
  // state and health tests
  reg [3:0]  state;
  reg [3:0]  next_state;
  reg [7:0]  run_len;
  reg        last_bit;
  reg [10:0] win_cnt;
  reg [10:0] ones_cnt;
  reg [3:0]  pass_wins;
  reg [3:0]  bit_cnt;
  reg [WORD_BITS-1:0] shift;
  reg        word_strobe;
  reg        ctrl_fault;
  wire       active;
  wire       total_fail;
  wire       win_end;
  wire       win_bad;
  wire       fault;
  wire       fifo_in_ready;
  wire [WORD_BITS-1:0] fifo_data;
  wire       fifo_valid;

  assign active     = (state == ST_TEST) || (state == ST_RUN);
  assign total_fail = active && (run_len >= RUN_LIMIT[7:0] - 8'h01)
                      && (raw_q == last_bit);
  assign win_end    = active && (win_cnt == WIN_BITS[10:0] - 11'h001);
  assign win_bad    = win_end && ((ones_cnt + {10'h000, raw_q}
                      < ONES_LO[10:0]) || (ones_cnt + {10'h000, raw_q}
                      > ONES_HI[10:0]));
  // control fault: state left one-hot, an enhanced variant check
  assign fault      = total_fail || win_bad || sw_shutdown
                      || ((ENHANCED != 0) && (alm_q || ctrl_fault));

  // an illegal state code can only come from an upset, so it fails hard
  always @* begin
    ctrl_fault = (state != ST_IDLE) && (state != ST_TEST)
                 && (state != ST_RUN) && (state != ST_FAIL);
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (start) next_state = ST_TEST;
      ST_TEST: begin
        // a start-up failure latches the flag just like a later one
        if (fault) begin
          next_state = ST_FAIL;
        end else if (win_end && pass_wins == STARTUP_WIN[3:0] - 4'h1) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:  if (fault) next_state = ST_FAIL;
      ST_FAIL: if (start) next_state = ST_TEST;
      default: next_state = ST_FAIL;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      run_len   <= 8'h00;
      last_bit  <= 1'b0;
      win_cnt   <= 11'h000;
      ones_cnt  <= 11'h000;
      pass_wins <= 4'h0;
    end else begin
      state    <= next_state;
      last_bit <= raw_q;
      // every state change restarts the tests on fresh bits
      if (!active || next_state != state) begin
        run_len   <= 8'h00;
        win_cnt   <= 11'h000;
        ones_cnt  <= 11'h000;
        if (next_state != ST_RUN) begin
          pass_wins <= 4'h0;
        end
      end else begin
        run_len <= (raw_q == last_bit) ? run_len + 8'h01 : 8'h00;
        if (win_end) begin
          win_cnt   <= 11'h000;
          ones_cnt  <= 11'h000;
          pass_wins <= pass_wins + 4'h1;
        end else begin
          win_cnt  <= win_cnt + 11'h001;
          ones_cnt <= ones_cnt + {10'h000, raw_q};
        end
      end
    end
  end

  // ========================================================
  // packing raw bits into words; stalls while fifo is full
  // samples taken during a stall are lost; a word is 16 adjacent ones
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt     <= 4'h0;
      shift       <= {WORD_BITS{1'b0}};
      word_strobe <= 1'b0;
    end else if (!active || fault) begin
      bit_cnt     <= 4'h0;
      word_strobe <= 1'b0;
    end else if (word_strobe && !fifo_in_ready) begin
      word_strobe <= 1'b1;
    end else begin
      shift       <= {shift[WORD_BITS-2:0], raw_q};
      bit_cnt     <= bit_cnt + 4'h1;
      word_strobe <= (bit_cnt == WORD_BITS[3:0] - 4'h1);
    end
  end

  // ========================================================
  // word buffer, flushed on any failure
  // also flushed outside run state so start-up words never leak out
  ptrng_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) ptrng_fifo_i (
    .clock     (clock),
    .resetn    (resetn),
    .flush     (state != ST_RUN || fault),
    .in_data   (shift),
    .in_valid  (word_strobe && state == ST_RUN),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (rnd_ready || !rnd_valid)
  );

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rnd_data     <= {WORD_BITS{1'b0}};
      rnd_valid    <= 1'b0;
      running      <= 1'b0;
      fail_sticky  <= 1'b0;
      startup_done <= 1'b0;
    end else begin
      running      <= (next_state == ST_RUN);
      startup_done <= (next_state == ST_RUN);
      if (next_state == ST_FAIL) begin
        fail_sticky <= 1'b1;
      end else if (state == ST_FAIL && start) begin
        fail_sticky <= 1'b0;
      end
      if (next_state != ST_RUN || fault) begin
        rnd_valid <= 1'b0;
        // no stale word stays on the pins once output closes
        rnd_data  <= {WORD_BITS{1'b0}};
      end else if (rnd_ready || !rnd_valid) begin
        rnd_valid <= fifo_valid;
        rnd_data  <= fifo_data;
      end
    end
  end
endmodule // ptrng_core

// ==== core/ptrng_defines.vh ====
`ifndef PTRNG_DEFINES_VH
`define PTRNG_DEFINES_VH

// ==========================================================
// word and test geometry
`define PTRNG_WORD_BITS      16
`define PTRNG_FIFO_DEPTH     8
// total failure: longest run of equal raw bits tolerated
`define PTRNG_RUN_LIMIT      64
// online test window in raw bits and accepted count of ones
`define PTRNG_WIN_BITS       1024
`define PTRNG_ONES_LO        432
`define PTRNG_ONES_HI        592
// start-up: number of passing windows before output opens
`define PTRNG_STARTUP_WINS   2

`endif

// ==== core/ptrng_fifo.v ====
`timescale 1ns/1ns
// ==========================================================
// synchronous fifo, registered read data
module ptrng_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clock,
  input  wire             resetn,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  wire            load;

  assign in_ready = (count != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  // output register reloads when empty or being taken
  assign load     = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  assign pop      = load;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_data  <= {WIDTH{1'b0}};
      out_valid <= 1'b0;
    end else if (flush) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_data  <= {WIDTH{1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr   <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      if (pop) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // ptrng_fifo

// ==== tb/ptrng_checker.sv ====
`timescale 1ns/1ns
// ==========================================================
// port checker
module ptrng_checker #(
  parameter WORD_BITS = 16,
  parameter ENHANCED  = 1,
  parameter RUN_LIMIT = 64
) (
  input logic                 clock,
  input logic                 resetn,
  input logic                 start,
  input logic                 sw_shutdown,
  input logic                 raw_bit,
  input logic                 attack_alarm,
  input logic [WORD_BITS-1:0] rnd_data,
  input logic                 rnd_valid,
  input logic                 rnd_ready,
  input logic                 running,
  input logic                 fail_sticky,
  input logic                 startup_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // sampled edges in a row with the source low while running
  int low_run;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_run <= 0;
    end else if (running && !raw_bit) begin
      low_run <= low_run + 1;
    end else begin
      low_run <= 0;
    end
  end
  AST_OUT_GATE: assert property (rnd_valid |-> running)
    else $error("word offered while not running");
  AST_FAIL_BLOCK: assert property (
    fail_sticky |-> !running && !rnd_valid)
    else $error("failure flag set with output open");
  AST_FAIL_HOLD: assert property (
    fail_sticky && !start |=> fail_sticky)
    else $error("failure flag cleared without restart");
  AST_RUN_EQ: assert property (running == startup_done)
    else $error("start-up flag differs from running");
  AST_OPEN_CLEAN: assert property (
    $rose(startup_done) |-> !rnd_valid && !fail_sticky)
    else $error("output open at the end of start-up");
  AST_DATA_HOLD: assert property (
    rnd_valid && !rnd_ready |=> !rnd_valid || $stable(rnd_data))
    else $error("word changed while waiting");
  AST_VALID_HOLD: assert property (
    rnd_valid && !rnd_ready |=> rnd_valid || fail_sticky)
    else $error("word dropped without failure");
  // sync latency plus detection: caught a few cycles past the run limit
  AST_STUCK: assert property (
    running && !raw_bit |-> low_run < RUN_LIMIT + 6)
    else $error("stuck source not caught");
  // the alarm input filter needs two agreeing samples
  AST_ALARM: assert property (
    (ENHANCED != 0) && attack_alarm && running ##1 attack_alarm
    |-> ##[1:5] !running)
    else $error("alarm did not stop generator");
  AST_SHUT: assert property (
    sw_shutdown && running |-> ##[1:5] fail_sticky)
    else $error("shutdown did not fail generator");
endmodule // ptrng_checker

bind ptrng_core ptrng_checker #(.WORD_BITS(WORD_BITS), .ENHANCED(ENHANCED),
  .RUN_LIMIT(RUN_LIMIT)) ptrng_checker_i (
  .clock(clock), .resetn(resetn), .start(start),
  .sw_shutdown(sw_shutdown), .raw_bit(raw_bit),
  .attack_alarm(attack_alarm), .rnd_data(rnd_data),
  .rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .running(running),
  .fail_sticky(fail_sticky), .startup_done(startup_done));

// ==== tb/ptrng_core_tb_top.sv ====
`timescale 1ns/1ns
// ==========================================================
// bench
module ptrng_core_tb_top;
  logic        clock = 0, resetn = 0, start = 0, sw_shutdown = 0;
  logic        raw_bit = 0, attack_alarm = 0, slow = 0;
  logic [1:0]  mode = 0;
  logic [2:0]  ph = 0;
  logic [15:0] rnd_data, got_data, first;
  logic        rnd_valid, rnd_ready, running, fail_sticky;
  logic        startup_done, got;
  int          fail_count = 0, cmp_count = 0, n;
  always #10 clock = ~clock;
  // mode 0 balanced 0011, 1 stuck low, 2 two in eight
  always @(posedge clock) begin
    ph <= ph + 3'h1;
    raw_bit <= mode == 2'h0 ? ph[1] : mode == 2'h2 && ph[2:1] == 2'h0;
  end
  ptrng_core #(.WIN_BITS(64), .ONES_LO(20), .ONES_HI(44), .RUN_LIMIT(8),
    .STARTUP_WIN(1)) ptrng_core_i (.clock(clock), .resetn(resetn),
    .start(start), .sw_shutdown(sw_shutdown), .raw_bit(raw_bit),
    .attack_alarm(attack_alarm), .rnd_data(rnd_data),
    .rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .running(running),
    .fail_sticky(fail_sticky), .startup_done(startup_done));
  ptrng_reader ptrng_reader_i (.clock(clock), .resetn(resetn), .slow(slow),
    .rnd_valid(rnd_valid), .rnd_data(rnd_data), .rnd_ready(rnd_ready),
    .got(got), .got_data(got_data));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // sampled at negedge, clear of the driving edge
  task wt(input int which, input int lim);
    n = 0;
    while ((which == 0 ? running : which == 1 ? fail_sticky : got) !== 1'b1
           && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (n >= lim) chk("wait", 16'h1, 16'h0);
  endtask
  task restart(input logic [1:0] m);
    @(posedge clock);
    mode <= m;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (2) @(negedge clock);
  endtask
  function logic [15:0] okw(input logic [15:0] w);
    return {15'h0, w inside {16'h3333, 16'h6666, 16'hcccc, 16'h9999}};
  endfunction
  task t_startup;
    restart(2'h0);
    n = 0;
    while (running !== 1'b1 && n < 400) begin
      chk("early valid", 16'h0, {15'h0, rnd_valid});
      @(negedge clock);
      n++;
    end
    wt(2, 100);
    first = got_data;
    chk("first word", 16'h1, okw(first));
    @(negedge clock);
    wt(2, 40);
    chk("next word", first, got_data);
    $display("startup test done");
  endtask
  task t_stuck;
    mode <= 2'h1;
    wt(1, 100);
    chk("running", 16'h0, {15'h0, running});
    repeat (40) @(negedge clock);
    chk("sticky", 16'h1, {15'h0, fail_sticky});
    $display("stuck test done");
  endtask
  task t_sparse;
    // settle the sparse pattern first so no long run trips the stuck test
    @(posedge clock);
    mode <= 2'h2;
    repeat (8) @(posedge clock);
    restart(2'h2);
    wt(1, 400);
    chk("never opened", 16'h0, {15'h0, startup_done});
    chk("window decided", 16'h1, {15'h0, n > 40});
    $display("sparse test done");
  endtask
  task t_fill;
    restart(2'h0);
    slow <= 1'b1;
    wt(0, 400);
    repeat (400) @(negedge clock);
    @(posedge clock);
    slow <= 1'b0;
    n = 0;
    repeat (12) @(negedge clock) n += got;
    chk("burst", 16'h1, {15'h0, n >= 8});
    chk("burst word", 16'h1, okw(got_data));
    @(posedge clock);
    sw_shutdown <= 1'b1;
    @(posedge clock);
    sw_shutdown <= 1'b0;
    wt(1, 10);
    chk("shut valid", 16'h0, {15'h0, rnd_valid});
    $display("fill test done");
  endtask
  task t_alarm;
    restart(2'h0);
    wt(0, 400);
    @(posedge clock);
    attack_alarm <= 1'b1;
    // two cycles: a one-cycle pulse never passes the input filter
    repeat (2) @(posedge clock);
    attack_alarm <= 1'b0;
    wt(1, 10);
    chk("alarm run", 16'h0, {15'h0, running});
    $display("alarm test done");
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    t_startup;
    t_stuck;
    t_sparse;
    t_fill;
    t_alarm;
    end_sim;
  end
  initial begin
    #200000;
    fail_count++;
    end_sim;
  end
endmodule // ptrng_core_tb_top

// ==== tb/ptrng_reader.sv ====
`timescale 1ns/1ns
// ==========================================================
// software reader: prompt, or one take in 64 cycles
module ptrng_reader (
  input  logic        clock,
  input  logic        resetn,
  input  logic        slow,
  input  logic        rnd_valid,
  input  logic [15:0] rnd_data,
  output logic        rnd_ready,
  output logic        got,
  output logic [15:0] got_data
);
  logic [5:0] cnt;
  assign rnd_ready = !slow || cnt == 6'h0;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= 6'h0;
      got <= 1'b0;
      got_data <= 16'h0;
    end else begin
      cnt <= cnt + 6'h1;
      got <= rnd_valid && rnd_ready;
      if (rnd_valid && rnd_ready) got_data <= rnd_data;
    end
  end
endmodule // ptrng_reader
